//--- rtl/irq_delivery_node.sv
// bus interrupt delivery: io port queues and posting, processor counters
`timescale 1ns/1ps
`include "irq_delivery_regs.svh"
module irq_delivery_node #(
    parameter int QUEUE_DEPTH = 4,
    parameter int CHANNELS = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // local register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // node identity
    input wire logic [3:0] node_id_i,
    // adapter requests
    input wire irq_delivery_pkg::adapter_req_t adp_req_i,
    output logic adp_accept_o,
    output logic adp_refuse_o,
    // bus snoop and response
    input wire irq_delivery_pkg::bus_cmd_t bus_cmd_i,
    output logic bus_confirm_o,
    output logic [31:0] bus_rdata_o,
    output logic bus_rdata_valid_o,
    // bus posting
    output irq_delivery_pkg::bus_cmd_t post_o,
    input wire logic post_gnt_i,
    // processor interrupt lines
    output logic [`IRQ_LEVELS-1:0] cpu_irq_o,
    output logic nonvec_irq_o
);
    localparam int L = `IRQ_LEVELS;
    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    // queue depth bounds pending per level
    if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > 4 || CHANNELS < 1 ||
        CHANNELS > (1 << `IRQ_CHAN_W)) begin : g_chk
        $error("unsupported queue depth or channel count");
    end

    // ****************************************
    // reset release
    // ****************************************
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ****************************************
    // bus decode
    // ****************************************
    logic req_wr;
    logic bcast_wr;
    logic [L-1:0] vec_hit;
    logic [1:0] req_lvl;
    logic [`IRQ_TARGETS-1:0] req_mask;
    logic eligible;
    logic targeted;

    assign req_wr = bus_cmd_i.valid && bus_cmd_i.write && (bus_cmd_i.addr == `IRQ_REQ_ADDR);
    assign bcast_wr = bus_cmd_i.valid && bus_cmd_i.write &&
        ((bus_cmd_i.addr & `IRQ_BCAST_MASK) == `IRQ_BCAST_BASE);
    assign req_lvl = bus_cmd_i.data[`IRQ_REQ_LVL_LSB +: 2];
    assign req_mask = bus_cmd_i.data[`IRQ_REQ_MASK_LSB +: `IRQ_TARGETS];
    // low node ids are target slots
    assign eligible = (node_id_i < 4'(`IRQ_TARGETS));
    assign targeted = eligible && req_mask[node_id_i[1:0]];

    // ****************************************
    // per-level queues and channel tracking
    // ****************************************
    irq_delivery_pkg::vec_entry_t head [L];
    logic [CW-1:0] qcnt [L];
    logic [L-1:0] push;
    logic [L-1:0] pop;
    logic [CHANNELS-1:0] chan_pend_q [L];
    logic [CW-1:0] unposted_q [L];
    logic [1:0] post_lvl_q;
    logic post_done;
    logic can_take;
    irq_delivery_pkg::vec_entry_t new_entry;

    assign new_entry.channel = adp_req_i.channel;
    assign new_entry.vector = adp_req_i.vector;
    assign can_take = !chan_pend_q[adp_req_i.level][adp_req_i.channel] &&
        (int'(adp_req_i.channel) < CHANNELS) && (qcnt[adp_req_i.level] != CW'(QUEUE_DEPTH));

    for (genvar l = 0; l < L; l++) begin : g_lvl
        assign vec_hit[l] = bus_cmd_i.valid && !bus_cmd_i.write &&
            (bus_cmd_i.addr == `IRQ_VEC_BASE + 22'(l) * `IRQ_VEC_STRIDE);
        assign push[l] = adp_req_i.valid && can_take && (adp_req_i.level == 2'(l));
        // a vector read services the head
        assign pop[l] = vec_hit[l] && (qcnt[l] != '0);

        vector_level_queue #(
            .DEPTH(QUEUE_DEPTH)
        ) u_queue (
            .clk_i(clk_i),
            .rst_n_i(rst_n),
            .push_i(push[l]),
            .push_data_i(new_entry),
            .pop_i(pop[l]),
            .head_o(head[l]),
            .count_o(qcnt[l])
        );

        // a channel frees when its vector is read
        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                chan_pend_q[l] <= '0;
            end else begin
                for (int c = 0; c < CHANNELS; c++) begin
                    if (push[l] && adp_req_i.channel == `IRQ_CHAN_W'(c)) begin
                        chan_pend_q[l][c] <= 1'b1;
                    end else if (pop[l] && head[l].channel == `IRQ_CHAN_W'(c)) begin
                        chan_pend_q[l][c] <= 1'b0;
                    end
                end
            end
        end

        // entries still waiting for their request write
        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                unposted_q[l] <= '0;
            end else begin
                unposted_q[l] <= unposted_q[l] + CW'(push[l])
                    - CW'((post_done && post_lvl_q == 2'(l) && unposted_q[l] != '0) ||
                          (pop[l] && unposted_q[l] == qcnt[l]));
            end
        end
    end

    // ****************************************
    // local registers
    // ****************************************
    logic [`IRQ_TARGETS-1:0] target_mask_q;
    logic [31:0] bcast_data_q;
    logic bcast_pend_q;
    logic nonvec_q;
    logic [L*`IRQ_CNT_W-1:0] pend_cnt;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            target_mask_q <= `IRQ_MASK_RST;
        end else if (reg_wr_i && reg_addr_i == `IRQ_REG_TARGET) begin
            target_mask_q <= reg_wdata_i[`IRQ_TARGETS-1:0];
        end
    end

    // non-vectored sticky flag: an arriving write beats the clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nonvec_q <= 1'b0;
        end else if (bcast_wr) begin
            nonvec_q <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == `IRQ_REG_NONVEC && reg_wdata_i[0]) begin
            nonvec_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 32'h0;
        end else begin
            reg_rdata_o <= 32'h0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `IRQ_REG_TARGET: reg_rdata_o <= 32'(target_mask_q);
                    `IRQ_REG_QSTAT: begin
                        for (int l = 0; l < L; l++) begin
                            reg_rdata_o[l*8 +: CW] <= qcnt[l];
                        end
                    end
                    `IRQ_REG_PEND: reg_rdata_o <= 32'(pend_cnt);
                    `IRQ_REG_NONVEC: reg_rdata_o <= {31'h0, nonvec_q};
                    default: reg_rdata_o <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************
    // posting engine
    // ****************************************
    irq_delivery_pkg::post_state_t state_q;
    logic [L-1:0] want;
    logic [1:0] pick;

    assign post_done = (state_q == irq_delivery_pkg::POST_VEC) && post_gnt_i;

    always_comb begin
        pick = 2'h0;
        for (int l = 0; l < L; l++) begin
            want[l] = (unposted_q[l] != '0);
            if (want[l]) begin
                pick = 2'(l);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bcast_pend_q <= 1'b0;
            bcast_data_q <= 32'h0;
        end else if (reg_wr_i && reg_addr_i == `IRQ_REG_BCAST) begin
            bcast_pend_q <= 1'b1;
            bcast_data_q <= reg_wdata_i;
        end else if (state_q == irq_delivery_pkg::POST_BCAST && post_gnt_i) begin
            bcast_pend_q <= 1'b0;
        end
    end

    // highest level first; vectored beats broadcast
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= irq_delivery_pkg::POST_IDLE;
            post_lvl_q <= 2'h0;
            post_o <= '0;
        end else begin
            case (state_q)
                irq_delivery_pkg::POST_IDLE: begin
                    if (want != '0 && target_mask_q != '0) begin
                        state_q <= irq_delivery_pkg::POST_VEC;
                        post_lvl_q <= pick;
                        post_o.valid <= 1'b1;
                        post_o.write <= 1'b1;
                        post_o.addr <= `IRQ_REQ_ADDR;
                        post_o.data <= 32'({pick, target_mask_q});
                    end else if (bcast_pend_q) begin
                        state_q <= irq_delivery_pkg::POST_BCAST;
                        post_o.valid <= 1'b1;
                        post_o.write <= 1'b1;
                        post_o.addr <= `IRQ_BCAST_BASE;
                        post_o.data <= bcast_data_q;
                    end
                end
                irq_delivery_pkg::POST_VEC, irq_delivery_pkg::POST_BCAST: begin
                    if (post_gnt_i) begin
                        state_q <= irq_delivery_pkg::POST_IDLE;
                        post_o <= '0;
                    end
                end
                default: begin
                    state_q <= irq_delivery_pkg::POST_IDLE;
                    post_o <= '0;
                end
            endcase
        end
    end

    // ****************************************
    // bus response
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_confirm_o <= 1'b0;
            bus_rdata_o <= 32'h0;
            bus_rdata_valid_o <= 1'b0;
        end else begin
            bus_confirm_o <= (vec_hit != '0) || (req_wr && targeted) || bcast_wr;
            bus_rdata_valid_o <= (vec_hit != '0);
            bus_rdata_o <= 32'h0;
            for (int l = 0; l < L; l++) begin
                // first reader takes head; empty reads zero
                if (vec_hit[l] && qcnt[l] != '0) begin
                    bus_rdata_o <= 32'(head[l].vector);
                end
            end
        end
    end

    // ****************************************
    // processor-side counters
    // ****************************************
    logic [L-1:0] cnt_inc;
    // count request writes naming this node
    always_comb begin
        for (int l = 0; l < L; l++) begin
            cnt_inc[l] = req_wr && targeted && (req_lvl == 2'(l));
        end
    end

    pending_counter_bank #(
        .LEVELS(L),
        .CNT_W(`IRQ_CNT_W)
    ) u_counters (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .inc_i(cnt_inc),
        .dec_i(vec_hit),
        .count_o(pend_cnt),
        .irq_o(cpu_irq_o)
    );

    // ****************************************
    // adapter handshake and non-vectored line
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            adp_accept_o <= 1'b0;
            adp_refuse_o <= 1'b0;
            nonvec_irq_o <= 1'b0;
        end else begin
            adp_accept_o <= adp_req_i.valid && can_take;
            adp_refuse_o <= adp_req_i.valid && !can_take;
            nonvec_irq_o <= nonvec_q;
        end
    end
endmodule

//--- rtl/irq_delivery_regs.svh
// offsets, field positions, reset values and counts for interrupt delivery
`ifndef IRQ_DELIVERY_REGS_SVH
`define IRQ_DELIVERY_REGS_SVH

// ****************************************
// bus csr space (22-bit csr addresses)
// ****************************************
`define IRQ_REQ_ADDR 22'h280000
`define IRQ_VEC_BASE 22'h280040
`define IRQ_VEC_STRIDE 22'h000040
`define IRQ_BCAST_BASE 22'h380000
`define IRQ_BCAST_MASK 22'h380000

// ****************************************
// request write data fields
// ****************************************
`define IRQ_REQ_MASK_LSB 0
`define IRQ_REQ_LVL_LSB 4

// ****************************************
// local register port offsets
// ****************************************
`define IRQ_REG_TARGET 8'h00
`define IRQ_REG_BCAST 8'h04
`define IRQ_REG_QSTAT 8'h08
`define IRQ_REG_PEND 8'h0c
`define IRQ_REG_NONVEC 8'h10

// ****************************************
// sizes and reset values
// ****************************************
`define IRQ_LEVELS 4
`define IRQ_TARGETS 4
`define IRQ_CHAN_W 4
`define IRQ_VEC_W 16
`define IRQ_CNT_W 7
`define IRQ_MASK_RST 4'h0

`endif

//--- rtl/irq_delivery_pkg.sv
// types shared by the interrupt delivery files
package irq_delivery_pkg;
    // bus command cycle as observed or issued
    typedef struct packed {
        logic valid;
        logic write;
        logic [21:0] addr;
        logic [31:0] data;
    } bus_cmd_t;

    // adapter interrupt request
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [3:0] channel;
        logic [15:0] vector;
    } adapter_req_t;

    // one queued vector with its source channel
    typedef struct packed {
        logic [3:0] channel;
        logic [15:0] vector;
    } vec_entry_t;

    typedef enum logic [1:0] {
        POST_IDLE = 2'b00,
        POST_VEC = 2'b01,
        POST_BCAST = 2'b11
    } post_state_t;
endpackage

//--- rtl/vector_level_queue.sv
// per-level vector queue holding accepted but unserviced vectors, posted or not
`timescale 1ns/1ps
module vector_level_queue #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // push and pop
    input wire logic push_i,
    input wire irq_delivery_pkg::vec_entry_t push_data_i,
    input wire logic pop_i,
    // state
    output irq_delivery_pkg::vec_entry_t head_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 1 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("queue depth must be a power of two");
    end

    irq_delivery_pkg::vec_entry_t mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic do_push;
    logic do_pop;

    // full queue refuses; caller also checks
    assign do_push = push_i && (cnt_q != CW'(DEPTH));
    assign do_pop = pop_i && (cnt_q != '0);
    assign head_o = mem_q[rd_q];
    assign count_o = cnt_q;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (do_pop) begin
                rd_q <= rd_q + AW'(1);
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + CW'(1);
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end
endmodule

//--- rtl/pending_counter_bank.sv
// processor-side pending interrupt counters, one per level
`timescale 1ns/1ps
module pending_counter_bank #(
    parameter int LEVELS = 4,
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // observed bus events
    input wire logic [LEVELS-1:0] inc_i,
    input wire logic [LEVELS-1:0] dec_i,
    // state
    output logic [LEVELS*CNT_W-1:0] count_o,
    output logic [LEVELS-1:0] irq_o
);
    if (LEVELS < 1 || CNT_W < 1) begin : g_chk
        $error("counter bank needs at least one level and one bit");
    end

    for (genvar l = 0; l < LEVELS; l++) begin : g_lvl
        logic [CNT_W-1:0] cnt_q;
        logic [CNT_W-1:0] cnt_d;
        logic irq_q;

        always_comb begin
            cnt_d = cnt_q;
            if (inc_i[l] && !dec_i[l] && cnt_q != '1) begin
                cnt_d = cnt_q + CNT_W'(1);
            end else if (dec_i[l] && !inc_i[l] && cnt_q != '0) begin
                cnt_d = cnt_q - CNT_W'(1);
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cnt_q <= '0;
                irq_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                irq_q <= (cnt_d != '0);
            end
        end

        assign count_o[l*CNT_W +: CNT_W] = cnt_q;
        assign irq_o[l] = irq_q;
    end
endmodule

//--- bench/bus_partner_model.sv
// bus model: grants posts, merges own posts with bench commands
`timescale 1ns/1ps
module bus_partner_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // node side
    input wire irq_delivery_pkg::bus_cmd_t post_i,
    output logic gnt_o,
    output irq_delivery_pkg::bus_cmd_t bus_o,
    // bench side
    input wire logic slow_i,
    input wire irq_delivery_pkg::bus_cmd_t ext_i
);
    logic [1:0] wait_q;
    logic gnt_q;
    irq_delivery_pkg::bus_cmd_t last_q;
    assign gnt_o = gnt_q;
    // ****
    // grant timing
    // ****
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_q <= 2'h0;
            gnt_q <= 1'b0;
        end else if (post_i.valid && !gnt_q) begin
            if (!slow_i || wait_q == 2'h3) begin
                gnt_q <= 1'b1;
                wait_q <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end else begin
            gnt_q <= 1'b0;
        end
    end
    // ****
    // bus wires
    // ****
    // reads and writes pass through
    // idle lines show inverted last value so stale data never matches
    always_comb begin
        if (gnt_q) begin
            bus_o = post_i;
        end else if (ext_i.valid) begin
            bus_o = ext_i;
        end else begin
            bus_o = {1'b0, ~last_q.write, ~last_q.addr, ~last_q.data};
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_q <= '0;
        end else if (bus_o.valid) begin
            last_q <= bus_o;
        end
    end
endmodule

//--- bench/irq_delivery_node_properties.sv
// port checks for the interrupt delivery node
`timescale 1ns/1ps
`include "irq_delivery_regs.svh"
module irq_delivery_node_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register and adapter
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [3:0] node_id_i,
    input wire irq_delivery_pkg::adapter_req_t adp_req_i,
    input wire logic adp_accept_o,
    input wire logic adp_refuse_o,
    // bus
    input wire irq_delivery_pkg::bus_cmd_t bus_cmd_i,
    input wire logic bus_confirm_o,
    input wire logic [31:0] bus_rdata_o,
    input wire logic bus_rdata_valid_o,
    input wire irq_delivery_pkg::bus_cmd_t post_o,
    input wire logic post_gnt_i,
    // lines
    input wire logic [3:0] cpu_irq_o,
    input wire logic nonvec_irq_o
);
    logic vec_rd, req_me, bcast_wr;
    logic [21:0] vec_off;
    logic [3:0] vec_oh, req_oh;
    assign vec_off = bus_cmd_i.addr - `IRQ_VEC_BASE;
    assign vec_rd = bus_cmd_i.valid && !bus_cmd_i.write && bus_cmd_i.addr >= `IRQ_VEC_BASE
        && vec_off < 22'h000100 && vec_off[5:0] == 6'h00;
    assign vec_oh = vec_rd ? (4'h1 << vec_off[7:6]) : 4'h0;
    assign req_me = bus_cmd_i.valid && bus_cmd_i.write && bus_cmd_i.addr == `IRQ_REQ_ADDR
        && node_id_i < 4'h4 && bus_cmd_i.data[node_id_i[1:0]];
    assign req_oh = req_me ? (4'h1 << bus_cmd_i.data[5:4]) : 4'h0;
    assign bcast_wr = bus_cmd_i.valid && bus_cmd_i.write
        && (bus_cmd_i.addr & `IRQ_BCAST_MASK) == `IRQ_BCAST_MASK;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_vec_read_answer: assert property (vec_rd |=> bus_rdata_valid_o && bus_confirm_o)
        else $error("vector read not answered");
    a_rdata_cause: assert property (
        bus_rdata_valid_o |-> $past(vec_rd) && bus_rdata_o[31:16] == 16'h0)
        else $error("read data without vector read");
    a_confirm_given: assert property (req_me || bcast_wr |=> bus_confirm_o)
        else $error("targeted write not confirmed");
    a_confirm_cause: assert property (
        bus_confirm_o |-> $past(vec_rd || req_me || bcast_wr))
        else $error("confirm without cause");
    a_req_raises_irq: assert property (
        req_me |=> (cpu_irq_o & $past(req_oh)) == $past(req_oh))
        else $error("request did not raise line");
    a_irq_rise_cause: assert property (
        (cpu_irq_o & ~$past(cpu_irq_o) & ~$past(req_oh)) == 4'h0)
        else $error("line rose without request");
    a_irq_fall_cause: assert property (
        (~cpu_irq_o & $past(cpu_irq_o) & ~$past(vec_oh)) == 4'h0)
        else $error("line fell without vector read");
    a_adp_answer: assert property (adp_req_i.valid |=> adp_accept_o != adp_refuse_o)
        else $error("adapter request not answered once");
    a_adp_cause: assert property (
        adp_accept_o || adp_refuse_o |-> $past(adp_req_i.valid))
        else $error("adapter answer without request");
    a_post_hold: assert property (post_o.valid && !post_gnt_i |=> $stable(post_o))
        else $error("post changed before grant");
    a_post_drop: assert property (post_o.valid && post_gnt_i |=> !post_o.valid)
        else $error("post held after grant");
    a_req_post_mask: assert property (
        post_o.valid && post_o.addr == `IRQ_REQ_ADDR |-> post_o.write && post_o.data[3:0] != 4'h0)
        else $error("request post without targets");
    a_bcast_flag: assert property (bcast_wr |-> ##[1:2] nonvec_irq_o)
        else $error("broadcast write did not flag");
    a_reg_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("register data outside read");
endmodule
bind irq_delivery_node irq_delivery_node_properties u_props (
    .clk_i, .reset_n_i, .reg_rd_i, .reg_rdata_o, .node_id_i, .adp_req_i, .adp_accept_o,
    .adp_refuse_o, .bus_cmd_i, .bus_confirm_o, .bus_rdata_o, .bus_rdata_valid_o, .post_o,
    .post_gnt_i, .cpu_irq_o, .nonvec_irq_o
);

//--- bench/irq_delivery_node_tb_top.sv
// self-checking bench for the interrupt delivery node
`timescale 1ns/1ps
`include "irq_delivery_regs.svh"
module irq_delivery_node_tb_top;
    logic clk_i, reset_n_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic reg_wr_i, reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic [3:0] node_id_i;
    irq_delivery_pkg::adapter_req_t adp_req_i;
    logic adp_accept_o, adp_refuse_o;
    irq_delivery_pkg::bus_cmd_t bus_cmd_i;
    logic bus_confirm_o;
    logic [31:0] bus_rdata_o;
    logic bus_rdata_valid_o;
    irq_delivery_pkg::bus_cmd_t post_o;
    logic post_gnt_i;
    logic [3:0] cpu_irq_o;
    logic nonvec_irq_o;
    irq_delivery_pkg::bus_cmd_t ext_q;
    logic slow_q;
    logic [31:0] last_post;
    int mismatches, samples_checked;
    irq_delivery_node u_dut (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .node_id_i, .adp_req_i, .adp_accept_o, .adp_refuse_o,
        .bus_cmd_i, .bus_confirm_o, .bus_rdata_o, .bus_rdata_valid_o, .post_o, .post_gnt_i,
        .cpu_irq_o, .nonvec_irq_o);
    bus_partner_model u_bus (.clk_i, .reset_n_i, .post_i(post_o), .gnt_o(post_gnt_i),
        .bus_o(bus_cmd_i), .slow_i(slow_q), .ext_i(ext_q));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (post_o.valid && post_gnt_i) last_post <= post_o.data;
    end
    // ****
    // tasks
    // ****
    task automatic close_out();
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic do_reset();
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(reg_rdata_o === exp, "register read");
    endtask
    task automatic bus(input logic w, input logic [21:0] a, input logic [31:0] d,
        input logic [31:0] exp);
        @(posedge clk_i);
        ext_q <= {1'b1, w, a, d};
        @(posedge clk_i);
        ext_q.valid <= 1'b0;
        @(negedge clk_i);
        if (!w) chk(bus_rdata_valid_o === 1'b1 && bus_rdata_o === exp, "vector read");
    endtask
    task automatic adp(input logic [1:0] l, input logic [3:0] c, input logic [15:0] v,
        input logic ok);
        @(posedge clk_i);
        adp_req_i <= {1'b1, l, c, v};
        @(posedge clk_i);
        adp_req_i.valid <= 1'b0;
        @(negedge clk_i);
        chk(adp_accept_o === ok && adp_refuse_o === !ok, "adapter answer");
    endtask
    // bounded wait: posting must go quiet for four cycles
    task automatic settle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 200 && quiet < 4; i++) begin
            @(negedge clk_i);
            quiet = post_o.valid ? 0 : quiet + 1;
        end
        if (quiet < 4) begin
            chk(1'b0, "posting never idle");
            close_out();
        end
    endtask
    function automatic logic [21:0] vaddr(input logic [1:0] l);
        return `IRQ_VEC_BASE + `IRQ_VEC_STRIDE * l;
    endfunction
    // ****
    // sequence
    // ****
    initial begin
        {reset_n_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, node_id_i} = '0;
        {adp_req_i, ext_q, slow_q} = '0;
        do_reset();
        rd(`IRQ_REG_TARGET, 32'h0);
        rd(`IRQ_REG_PEND, 32'h0);
        rd(8'h20, 32'h0);
        wr(`IRQ_REG_QSTAT, 32'hffffffff);
        rd(`IRQ_REG_QSTAT, 32'h0);
        wr(`IRQ_REG_TARGET, 32'h5);
        rd(`IRQ_REG_TARGET, 32'h5);
        $display("registers done");
        slow_q <= 1'b1;
        adp(2'h2, 4'h5, 16'hbeef, 1'b1);
        adp(2'h2, 4'h5, 16'h1111, 1'b0);
        adp(2'h2, 4'h6, 16'hcafe, 1'b1);
        settle();
        chk(last_post === 32'h25, "request post data");
        rd(`IRQ_REG_PEND, 32'h8000);
        chk(cpu_irq_o === 4'h4, "level two line");
        slow_q <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            adp(2'h1, c[3:0], 16'h0100 + c[15:0], c < 4);
        end
        settle();
        rd(`IRQ_REG_QSTAT, 32'h00020400);
        rd(`IRQ_REG_PEND, 32'h8200);
        $display("queueing done");
        bus(1'b0, vaddr(2'h2), 32'h0, 32'hbeef);
        bus(1'b0, vaddr(2'h2), 32'h0, 32'hcafe);
        bus(1'b0, vaddr(2'h2), 32'h0, 32'h0);
        rd(`IRQ_REG_PEND, 32'h200);
        for (int c = 0; c < 4; c++) begin
            bus(1'b0, vaddr(2'h1), 32'h0, 32'h0100 + c);
        end
        rd(`IRQ_REG_PEND, 32'h0);
        chk(cpu_irq_o === 4'h0, "lines clear");
        $display("servicing done");
        bus(1'b1, `IRQ_REQ_ADDR, 32'h3e, 32'h0);
        rd(`IRQ_REG_PEND, 32'h0);
        for (int i = 0; i < 130; i++) begin
            bus(1'b1, `IRQ_REQ_ADDR, 32'h31, 32'h0);
        end
        rd(`IRQ_REG_PEND, 32'h0fe00000);
        @(posedge clk_i);
        node_id_i <= 4'h5;
        bus(1'b1, `IRQ_REQ_ADDR, 32'h0f, 32'h0);
        rd(`IRQ_REG_PEND, 32'h0fe00000);
        @(posedge clk_i);
        node_id_i <= 4'h1;
        bus(1'b1, `IRQ_REQ_ADDR, 32'h02, 32'h0);
        rd(`IRQ_REG_PEND, 32'h0fe00001);
        $display("targeting done");
        bus(1'b1, `IRQ_BCAST_BASE, 32'h1, 32'h0);
        rd(`IRQ_REG_NONVEC, 32'h1);
        chk(nonvec_irq_o === 1'b1, "nonvectored line");
        wr(`IRQ_REG_NONVEC, 32'h1);
        rd(`IRQ_REG_NONVEC, 32'h0);
        wr(`IRQ_REG_BCAST, 32'h5a);
        settle();
        chk(last_post === 32'h5a, "broadcast post data");
        rd(`IRQ_REG_NONVEC, 32'h1);
        rd(`IRQ_REG_BCAST, 32'h0);
        $display("broadcast done");
        do_reset();
        rd(`IRQ_REG_PEND, 32'h0);
        rd(`IRQ_REG_TARGET, 32'h0);
        $display("second reset done");
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        chk(1'b0, "run too long");
        close_out();
    end
endmodule
